// ==== logic/irq_pkg.sv ====
// Shared constants for the prioritised interrupt controller.
// Assumes an 8-bit register port with a 4-bit address and a single system clock.
package irq_pkg;

  // Register addresses on the plain register port
  localparam logic [3:0] ADDR_STAT1 = 4'h0;
  localparam logic [3:0] ADDR_STAT2 = 4'h1;
  localparam logic [3:0] ADDR_STAT3 = 4'h2;
  localparam logic [3:0] ADDR_EN_LO = 4'h3;
  localparam logic [3:0] ADDR_EN_HI = 4'h4;
  localparam logic [3:0] ADDR_FLAG_LO = 4'h5;
  localparam logic [3:0] ADDR_FLAG_HI = 4'h6;
  localparam logic [3:0] ADDR_ASYNC_EN = 4'h7;
  localparam logic [3:0] ADDR_CORE = 4'h8;

  // Positions in the latched flag vector and in the enable vector
  localparam int NUM_FLAGS = 15;
  localparam int FL_EXT = 0;
  localparam int FL_CLK_MONITOR_ENABLE = 1;
  localparam int FL_T1C0 = 2;
  localparam int FL_T1C1 = 3;
  localparam int FL_T1OF = 4;
  localparam int FL_T2C0 = 5;
  localparam int FL_T2C1 = 6;
  localparam int FL_T2OF = 7;
  localparam int FL_SPRX = 8;
  localparam int FL_SPOVF = 9;
  localparam int FL_SPMODF = 10;
  localparam int FL_SPTX = 11;
  localparam int FL_KEY = 12;
  localparam int FL_CONV = 13;
  localparam int FL_TICK = 14;
  // Enable bits that differ in meaning from the flag at the same position
  localparam int EN_SPERR = 9;
  localparam int EN_SP_MODE_FAULT_FLAG_DET = 10;
  localparam int EN_CLK_MONITOR_ENABLE_ON = 15;

  // Positions of the asynchronous serial flags on their input vector
  localparam int AS_OVR = 0;
  localparam int AS_NOISE = 1;
  localparam int AS_FRAME = 2;
  localparam int AS_PARITY = 3;
  localparam int AS_RXFULL = 4;
  localparam int AS_IDLE = 5;
  localparam int AS_TXEMPTY = 6;
  localparam int AS_TXDONE = 7;

  // Priorities and vectors
  localparam int NUM_PRIO = 16;
  localparam logic [4:0] IDX_TRAP = 5'h00;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;

  // Values after reset
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [7:0] ASYNC_EN_RESET = 8'h00;
  localparam logic GMASK_RESET = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STACK = 2'b01,
    ST_FETCH = 2'b10
  } seq_state_type;

endpackage : irq_pkg

// ==== logic/irq_flag_bank.sv ====
// Bank of sticky event flags, one flip-flop per flag.
// Assumes set and clear pulses are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank #(
  parameter int N = 15
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flag
);

  logic [N-1:0] next_flag;

  // A set in the same cycle as a clear wins, so no event is lost
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_comb begin
        next_flag[g] = set[g] | (flag[g] & ~clr[g]);
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : irq_flag_bank
`default_nettype wire

// ==== logic/irq_pick.sv ====
// Picks the lowest-numbered active request; bit 0 of req is priority 1.
// Purely combinational, result is registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module irq_pick #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [4:0] prio
);

  // Scan from the weakest down so the strongest request is written last
  always_comb begin
    any = |req;
    prio = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        prio = 5'(i + 1);
      end
    end
  end

endmodule : irq_pick
`default_nettype wire

// ==== logic/irq_ctrl.sv ====
// Interrupt recognition, prioritisation and entry sequencing for the 8-bit core.
// Assumes core and peripheral strobes are synchronous to clk_sys and one cycle long.
// Behaviour
// (RQ1) Entry starts only at an instruction boundary, never mid-instruction.
// (RQ2) Entry asks the core to stack registers; return restores them.
// (RQ3) Entry sets the global mask so nothing pre-empts the taken request.
// (RQ4) Maskable requests are examined at each boundary only while mask clear.
// (RQ5) Among pending requests the lowest priority number wins.
// (RQ6) A request pending at return is taken before the next program instruction.
// (RQ7) The high index register is never stacked on entry.
// (RQ8) Software trap ignores the mask and stacks PC, not PC minus one.
// (RQ9) Global mask blocks all but the trap; request needs flag and enable; priorities 1 and 14 need their enable bit clear.
// (RQ10) Fixed two-byte vectors: reset and trap priority 0, sources 1-16 to FFDC.
// (RQ11) Several flag-enable pairs OR onto one status bit and vector.
// (RQ12) A debug break point forces the core to execute the software trap.
// (RQ13) Low external pin latches a priority 1 request gated by its mask.
// (RQ14) Clock monitor flag sets when selected clock goes inactive while enabled.
// (RQ15) Each timer overflow flag sets on wrap, gated by its overflow enable.
// (RQ16) Each timer channel flag sets on capture or compare, gated by its enable.
// (RQ17) Serial peripheral receive-full flag sets on each byte loaded, gated by enable.
// (RQ18) Serial peripheral transmit-empty flag sets on each load, requests priority 10.
// (RQ19) Mode fault: slave on select rising mid-transfer, master on select low.
// (RQ20) Overflow when new byte arrives before old one read; error enable gates both.
// (RQ21) Each pending status bit reads 1 exactly while its request is present.
// (RQ22) Status one bits 1-0 and status three bits 7-2 read zero.
// (RQ23) Vector index and request line stay stable from decision to fetch end.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl
  import irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic insn_done,
  input wire logic trap_insn_done,
  input wire logic sei_exec,
  input wire logic cli_exec,
  input wire logic rti_done,
  input wire logic rti_mask,
  input wire logic break_match,
  output logic force_trap_insn,
  output logic irq_req,
  output logic [4:0] irq_vector_idx,
  output logic [15:0] irq_vector_addr,
  output logic push_pc_minus_one,
  output logic push_high_index,
  input wire logic stack_done,
  input wire logic fetch_done,
  output logic global_mask,
  input wire logic ext_pin_n,
  input wire logic clk_inactive,
  input wire logic [3:0] timer_ch_evt,
  input wire logic [1:0] timer_wrap_evt,
  input wire logic sp_rx_load,
  input wire logic sp_rx_read,
  input wire logic sp_tx_load,
  input wire logic sp_master,
  input wire logic sp_ss_n,
  input wire logic sp_busy,
  input wire logic [7:0] async_flag,
  input wire logic key_n,
  input wire logic conv_done,
  input wire logic tick_rollover
);

  logic [15:0] enab;
  logic [15:0] next_enab;
  logic [7:0] async_en;
  logic [7:0] next_async_en;
  logic [7:0] next_rdata;
  logic ss_prev;
  logic next_ss_prev;
  logic next_force_trap;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flag;
  logic [NUM_PRIO:1] pend;
  logic pend_any;
  logic [4:0] pend_prio;
  seq_state_type state;
  seq_state_type next_state;
  logic next_gmask;
  logic [4:0] next_idx;
  logic [15:0] next_addr;
  logic next_pc_adj;
  logic eff_mask;
  logic take_trap;
  logic take_irq;

  // Event sources set their sticky flags
  always_comb begin
    flag_set = '0;
    flag_set[FL_EXT] = ~ext_pin_n; // [RQ13]
    flag_set[FL_CLK_MONITOR_ENABLE] = enab[EN_CLK_MONITOR_ENABLE_ON] & clk_inactive; // [RQ14]
    flag_set[FL_T1C0] = timer_ch_evt[0]; // [RQ16]
    flag_set[FL_T1C1] = timer_ch_evt[1];
    flag_set[FL_T2C0] = timer_ch_evt[2];
    flag_set[FL_T2C1] = timer_ch_evt[3];
    flag_set[FL_T1OF] = timer_wrap_evt[0]; // [RQ15]
    flag_set[FL_T2OF] = timer_wrap_evt[1];
    flag_set[FL_SPRX] = sp_rx_load; // [RQ17]
    flag_set[FL_SPOVF] = sp_rx_load & flag[FL_SPRX]; // [RQ20]
    // Slave fault on select rising mid-transfer, master fault while select is low
    flag_set[FL_SPMODF] = enab[EN_SP_MODE_FAULT_FLAG_DET] &
      ((~sp_master & sp_busy & ~ss_prev & sp_ss_n) | (sp_master & ~sp_ss_n)); // [RQ19]
    flag_set[FL_SPTX] = sp_tx_load; // [RQ18]
    flag_set[FL_KEY] = ~key_n;
    flag_set[FL_CONV] = conv_done;
    flag_set[FL_TICK] = tick_rollover;
  end

  // Write-one-to-clear from software; a data read retires the receive-full flag
  always_comb begin
    flag_clr = '0;
    if (reg_wr && reg_addr == ADDR_FLAG_LO) begin
      flag_clr[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_FLAG_HI) begin
      flag_clr[NUM_FLAGS-1:8] = reg_wdata[NUM_FLAGS-9:0];
    end
    flag_clr[FL_SPRX] = flag_clr[FL_SPRX] | sp_rx_read;
  end

  irq_flag_bank #(
    .N(NUM_FLAGS)
  ) u_flags (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .set(flag_set),
    .clr(flag_clr),
    .flag(flag)
  );

  // Requests: flag and enable pairs, shared vectors OR several pairs together
  always_comb begin
    pend[1] = flag[FL_EXT] & ~enab[FL_EXT]; // [RQ13] [RQ9]
    pend[2] = flag[FL_CLK_MONITOR_ENABLE] & enab[FL_CLK_MONITOR_ENABLE]; // [RQ14]
    pend[3] = flag[FL_T1C0] & enab[FL_T1C0]; // [RQ16]
    pend[4] = flag[FL_T1C1] & enab[FL_T1C1];
    pend[5] = flag[FL_T1OF] & enab[FL_T1OF]; // [RQ15]
    pend[6] = flag[FL_T2C0] & enab[FL_T2C0];
    pend[7] = flag[FL_T2C1] & enab[FL_T2C1];
    pend[8] = flag[FL_T2OF] & enab[FL_T2OF];
    pend[9] = (flag[FL_SPRX] & enab[FL_SPRX]) |
              ((flag[FL_SPOVF] | flag[FL_SPMODF]) & enab[EN_SPERR]); // [RQ11] [RQ17] [RQ20]
    pend[10] = flag[FL_SPTX] & enab[FL_SPTX]; // [RQ18]
    pend[11] = |(async_flag[AS_PARITY:AS_OVR] & async_en[AS_PARITY:AS_OVR]); // [RQ11]
    pend[12] = |(async_flag[AS_IDLE:AS_RXFULL] & async_en[AS_IDLE:AS_RXFULL]);
    pend[13] = |(async_flag[AS_TXDONE:AS_TXEMPTY] & async_en[AS_TXDONE:AS_TXEMPTY]);
    pend[14] = flag[FL_KEY] & ~enab[FL_KEY];
    pend[15] = flag[FL_CONV] & enab[FL_CONV];
    pend[16] = flag[FL_TICK] & enab[FL_TICK];
  end

  irq_pick #(
    .N(NUM_PRIO)
  ) u_pick (
    .req(pend),
    .any(pend_any),
    .prio(pend_prio) // [RQ5]
  );

  // Register writes, read data and small side state
  always_comb begin
    next_enab = enab;
    next_async_en = async_en;
    next_rdata = 8'h00;
    next_ss_prev = sp_ss_n;
    next_force_trap = break_match; // [RQ12]
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_EN_LO: next_enab[7:0] = reg_wdata;
        ADDR_EN_HI: next_enab[15:8] = reg_wdata;
        ADDR_ASYNC_EN: next_async_en = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STAT1: next_rdata = {pend[6:1], 2'b00}; // [RQ21] [RQ22]
        ADDR_STAT2: next_rdata = pend[14:7];
        ADDR_STAT3: next_rdata = {6'h00, pend[16:15]}; // [RQ22]
        ADDR_EN_LO: next_rdata = enab[7:0];
        ADDR_EN_HI: next_rdata = enab[15:8];
        ADDR_FLAG_LO: next_rdata = flag[7:0];
        ADDR_FLAG_HI: next_rdata = {1'b0, flag[NUM_FLAGS-1:8]};
        ADDR_ASYNC_EN: next_rdata = async_en;
        ADDR_CORE: next_rdata = {5'h00, state != ST_IDLE, pend_any, global_mask};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enab <= EN_RESET;
      async_en <= ASYNC_EN_RESET;
      reg_rdata <= 8'h00;
      ss_prev <= 1'b1;
      force_trap_insn <= 1'b0;
    end else begin
      enab <= next_enab;
      async_en <= next_async_en;
      reg_rdata <= next_rdata;
      ss_prev <= next_ss_prev;
      force_trap_insn <= next_force_trap;
    end
  end

  // Boundary decision; a return restores the mask it also decides with
  always_comb begin
    eff_mask = rti_done ? rti_mask : global_mask; // [RQ6]
    take_trap = (state == ST_IDLE) && insn_done && trap_insn_done; // [RQ8]
    take_irq = (state == ST_IDLE) && insn_done && !trap_insn_done && !eff_mask && pend_any; // [RQ1] [RQ4] [RQ9]
  end

  // Entry sequencer: stack, then vector fetch; selection frozen until fetch ends
  always_comb begin
    next_state = state;
    next_gmask = global_mask;
    next_idx = irq_vector_idx;
    next_addr = irq_vector_addr;
    next_pc_adj = push_pc_minus_one;
    if (rti_done) begin
      next_gmask = rti_mask; // [RQ2]
    end else if (sei_exec) begin
      next_gmask = 1'b1;
    end else if (cli_exec) begin
      next_gmask = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (take_trap || take_irq) begin
          next_state = ST_STACK; // [RQ2]
          next_gmask = 1'b1; // [RQ3]
          next_idx = take_trap ? IDX_TRAP : pend_prio;
          // Trap slot is just under reset; each priority steps down one word
          next_addr = VEC_TRAP - {10'h000, (take_trap ? IDX_TRAP : pend_prio), 1'b0}; // [RQ10]
          next_pc_adj = take_irq; // [RQ8]
        end
      end
      ST_STACK: begin
        next_gmask = 1'b1;
        if (stack_done) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_gmask = 1'b1;
        if (fetch_done) begin
          next_state = ST_IDLE; // [RQ23]
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      global_mask <= GMASK_RESET;
      irq_vector_idx <= IDX_TRAP;
      irq_vector_addr <= VEC_RESET;
      push_pc_minus_one <= 1'b0;
    end else begin
      state <= next_state;
      global_mask <= next_gmask;
      irq_vector_idx <= next_idx;
      irq_vector_addr <= next_addr;
      push_pc_minus_one <= next_pc_adj;
    end
  end

  // Request line is a handshake, valid for the whole stack and fetch
  assign irq_req = (state != ST_IDLE); // [RQ23]
  // Never stacked: a service routine that touches the high index saves it itself
  assign push_high_index = 1'b0; // [RQ7]

  // Checks
  logic [16:0] pend_d;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_d <= 17'h00000;
    end else begin
      pend_d <= {pend, 1'b0};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  AST_ENTRY_AT_BOUNDARY: assert property ($rose(irq_req) |-> $past(insn_done)) // [RQ1]
    else $error("interrupt entry without a completed instruction");
  AST_MASK_ON_ENTRY: assert property ($rose(irq_req) |-> global_mask ##1 global_mask) // [RQ3]
    else $error("global mask not set on entry");
  AST_MASKED_HELD: assert property (state == ST_IDLE && insn_done && eff_mask && !trap_insn_done // [RQ4]
    |=> !irq_req)
    else $error("maskable request taken while masked");
  AST_LOWEST_WINS: assert property ($rose(irq_req) && irq_vector_idx != 5'h00 // [RQ5]
    |-> pend_d[irq_vector_idx] && ((pend_d & ((17'h00001 << irq_vector_idx) - 17'h00001)) == 17'h00000))
    else $error("picked request is not the highest priority");
  AST_RTI_PENDING: assert property (state == ST_IDLE && insn_done && rti_done && !rti_mask && pend_any // [RQ6]
    |=> irq_req)
    else $error("request pending at return not taken");
  AST_TRAP_UNMASKED: assert property (state == ST_IDLE && insn_done && trap_insn_done // [RQ8]
    |=> irq_req && irq_vector_idx == 5'h00 && !push_pc_minus_one)
    else $error("software trap not taken or wrong stacking");
  AST_VECTOR_ADDR: assert property (irq_req |-> irq_vector_addr == VEC_TRAP - {10'h000, irq_vector_idx, 1'b0}) // [RQ10]
    else $error("vector address does not match priority");
  AST_BREAK_TRAP: assert property (break_match |=> force_trap_insn) // [RQ12]
    else $error("break point did not force a trap");
  AST_EXT_LATCH: assert property (!ext_pin_n |=> flag[FL_EXT]) // [RQ13]
    else $error("low external pin did not latch");
  AST_SP_OVERFLOW: assert property (sp_rx_load && flag[FL_SPRX] |=> flag[FL_SPOVF]) // [RQ20]
    else $error("overflow not flagged");
  AST_STAT3_ZERO: assert property (reg_rd && reg_addr == ADDR_STAT3 |=> reg_rdata[7:2] == 6'h00) // [RQ22]
    else $error("reserved status bits not zero");
  AST_SEL_STABLE: assert property (irq_req && $past(irq_req) |-> $stable(irq_vector_idx) && $stable(irq_vector_addr)) // [RQ23]
    else $error("vector selection changed during entry");

  // Mode fault watched against the raw select pin, not against the delayed copy the logic uses
  AST_FAULT_CAUSE: assert property (!flag[FL_SPMODF] && !(enab[EN_SP_MODE_FAULT_FLAG_DET] && sp_master && !sp_ss_n) // [RQ19]
    && !(enab[EN_SP_MODE_FAULT_FLAG_DET] && !sp_master && sp_busy && $rose(sp_ss_n)) |=> !flag[FL_SPMODF])
    else $error("mode fault flagged without a cause");
  AST_SLAVE_FAULT: assert property (enab[EN_SP_MODE_FAULT_FLAG_DET] && !sp_master && sp_busy && $rose(sp_ss_n) // [RQ19]
    |=> flag[FL_SPMODF])
    else $error("slave mode fault not flagged");
  AST_MASTER_FAULT: assert property (enab[EN_SP_MODE_FAULT_FLAG_DET] && sp_master && !sp_ss_n |=> flag[FL_SPMODF]) // [RQ19]
    else $error("master mode fault not flagged");
  AST_STAT1_ZERO: assert property (reg_rd && reg_addr == ADDR_STAT1 |=> reg_rdata[1:0] == 2'b00) // [RQ22]
    else $error("reserved status bits not zero");
  AST_NO_HIGH_INDEX: assert property (irq_req |-> !push_high_index) // [RQ7]
    else $error("high index stacked on entry");
  AST_WRAP_LATCH: assert property (timer_wrap_evt[0] |=> flag[FL_T1OF]) // [RQ15]
    else $error("timer wrap did not latch");
  AST_IDLE_OFF_BOUNDARY: assert property (state == ST_IDLE && !insn_done |=> !irq_req) // [RQ1]
    else $error("entry started between boundaries");

endmodule : irq_ctrl
`default_nettype wire

// ==== dv/irq_core_model.sv ====
// Behavioural model of the core side of interrupt entry: stacking, then vector fetch.
// Assumes irq_req is a level from the controller and resp_delay is held steady during an entry.
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic irq_req,
  input wire logic [3:0] resp_delay,
  output logic stack_done,
  output logic fetch_done
);
  // One entry at a time; a nonzero delay models a slow core and stretches the hold window
  initial begin
    stack_done = 1'b0;
    fetch_done = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (rstn === 1'b1 && irq_req === 1'b1) begin
        repeat (resp_delay) @(posedge clk_sys);
        stack_done <= 1'b1; // Registers pushed, index high byte left alone
        @(posedge clk_sys);
        stack_done <= 1'b0;
        repeat (resp_delay) @(posedge clk_sys);
        fetch_done <= 1'b1; // Two-byte vector read from the presented location
        @(posedge clk_sys);
        fetch_done <= 1'b0;
      end
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ==== dv/prioritized_cpu_interrupt_logic_tb_top.sv ====
// Self-checking testbench for the interrupt controller: register port tasks and entry scenarios.
// Assumes irq_pkg and the core model are compiled first; no random stimulus.
`timescale 1ns/1ps
`default_nettype none
module prioritized_cpu_interrupt_logic_tb_top
  import irq_pkg::*;
;
  logic clk_sys, rstn, reg_wr, reg_rd, insn_done, trap_insn_done, sei_exec, cli_exec, rti_done, rti_mask;
  logic break_match, force_trap_insn, irq_req, push_pc_minus_one, push_high_index, stack_done, fetch_done;
  logic global_mask, ext_pin_n, clk_inactive, sp_rx_load, sp_rx_read, sp_tx_load, sp_master, sp_ss_n, sp_busy;
  logic key_n, conv_done, tick_rollover;
  logic [3:0] reg_addr, timer_ch_evt, resp_delay;
  logic [7:0] reg_wdata, reg_rdata, async_flag, rd_val;
  logic [4:0] irq_vector_idx;
  logic [15:0] irq_vector_addr;
  logic [1:0] timer_wrap_evt;
  logic [16:0] e;
  int miscompares, num_checks, p;

  irq_ctrl u_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .insn_done,
    .trap_insn_done, .sei_exec, .cli_exec, .rti_done, .rti_mask, .break_match, .force_trap_insn, .irq_req,
    .irq_vector_idx, .irq_vector_addr, .push_pc_minus_one, .push_high_index, .stack_done, .fetch_done,
    .global_mask, .ext_pin_n, .clk_inactive, .timer_ch_evt, .timer_wrap_evt, .sp_rx_load, .sp_rx_read,
    .sp_tx_load, .sp_master, .sp_ss_n, .sp_busy, .async_flag, .key_n, .conv_done, .tick_rollover);

  irq_core_model u_core (.clk_sys, .rstn, .irq_req, .resp_delay, .stack_done, .fetch_done);

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Single compare for all result kinds; case inequality so unknowns never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Register write: one strobe cycle, a quiet cycle after so the strobe is never reassigned at one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Register read: data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk({8'h00, rd_val}, {8'h00, exp});
  endtask : rd_chk

  // Instruction boundary, optionally a trap or a return completing there
  task automatic boundary(input logic trap, input logic return_from_irq_insn);
    @(posedge clk_sys);
    insn_done <= 1'b1;
    trap_insn_done <= trap;
    rti_done <= return_from_irq_insn;
    @(posedge clk_sys);
    insn_done <= 1'b0;
    trap_insn_done <= 1'b0;
    rti_done <= 1'b0;
    #1;
  endtask : boundary

  // Entry outputs, then the selection held for the whole entry under a bounded wait
  task automatic entry(input logic [4:0] idx);
    int n;
    chk({15'h0000, irq_req}, 16'h0001);
    chk(irq_vector_addr, 16'hFFFC - {10'h000, idx, 1'b0});
    chk({14'h0000, push_pc_minus_one, push_high_index}, {14'h0000, idx != IDX_TRAP, 1'b0});
    chk({15'h0000, global_mask}, 16'h0001);
    for (n = 0; n < 40 && irq_req === 1'b1; n++) begin
      chk({11'h000, irq_vector_idx}, {11'h000, idx});
      @(posedge clk_sys);
      #1;
    end
    if (n == 40) begin
      miscompares++;
      finish_test();
    end
  endtask : entry

  // One source event; pulses last one cycle, two for the receive load of 18 and busy of 20; live serial flags stay until cleanup
  task automatic fire(input int s);
    @(posedge clk_sys);
    case (s)
      1: ext_pin_n <= 1'b0;
      2: clk_inactive <= 1'b1;
      3: timer_ch_evt <= 4'h1;
      4: timer_ch_evt <= 4'h2;
      5: timer_wrap_evt <= 2'h1;
      6: timer_ch_evt <= 4'h4;
      7: timer_ch_evt <= 4'h8;
      8: timer_wrap_evt <= 2'h2;
      9, 18: sp_rx_load <= 1'b1;
      10: sp_tx_load <= 1'b1;
      11: async_flag <= 8'h01 << AS_PARITY;
      12: async_flag <= 8'h01 << AS_RXFULL;
      13: async_flag <= 8'h01 << AS_TXEMPTY;
      14: key_n <= 1'b0;
      15: conv_done <= 1'b1;
      16: tick_rollover <= 1'b1;
      17: sp_ss_n <= 1'b0;
      19: async_flag <= 8'h01 << AS_TXDONE;
      20: begin
        sp_busy <= 1'b1;
        sp_ss_n <= 1'b0;
      end
      default: ;
    endcase
    sp_master <= (s == 17);
    @(posedge clk_sys);
    ext_pin_n <= 1'b1;
    key_n <= 1'b1;
    clk_inactive <= 1'b0;
    timer_ch_evt <= 4'h0;
    timer_wrap_evt <= 2'h0;
    sp_tx_load <= 1'b0;
    conv_done <= 1'b0;
    tick_rollover <= 1'b0;
    sp_master <= 1'b0;
    sp_ss_n <= 1'b1;
    sp_rx_load <= (s == 18); // Second load before any read makes an overflow
    sp_busy <= (s == 20); // Select rises while the slave is still busy
    @(posedge clk_sys);
    sp_rx_load <= 1'b0;
    sp_busy <= 1'b0;
  endtask : fire

  // Main sequence: reset, register map, every source, entry ordering, trap and break
  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, insn_done, trap_insn_done, sei_exec, cli_exec, rti_done, rti_mask} = 8'h00;
    {break_match, clk_inactive, sp_rx_load, sp_rx_read, sp_tx_load, sp_master, sp_busy} = 7'h00;
    {ext_pin_n, key_n, sp_ss_n} = 3'h7;
    {conv_done, tick_rollover} = 2'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    timer_ch_evt = 4'h0;
    timer_wrap_evt = 2'h0;
    async_flag = 8'h00;
    resp_delay = 4'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    chk(irq_vector_addr, VEC_RESET);
    for (int a = 0; a < 16; a++) begin
      rd_chk(4'(a), (a == 8) ? 8'h01 : 8'h00);
    end
    wr(ADDR_CORE, 8'hFF);
    rd_chk(ADDR_CORE, 8'h01);
    wr(ADDR_EN_LO, 8'hFE);
    wr(ADDR_EN_HI, 8'hEF);
    wr(ADDR_ASYNC_EN, 8'hFF);
    rd_chk(ADDR_EN_HI, 8'hEF);
    for (int s = 1; s <= 20; s++) begin
      p = (s == 17 || s == 18 || s == 20) ? 9 : (s == 19) ? 13 : s;
      e = 17'h00001 << p;
      fire(s);
      if (s == 18) begin
        // Software reads the byte, so only the overflow remains
        sp_rx_read <= 1'b1;
        @(posedge clk_sys);
        sp_rx_read <= 1'b0;
      end
      rd_chk(ADDR_STAT1, {e[6:1], 2'b00});
      rd_chk(ADDR_STAT2, e[14:7]);
      rd_chk(ADDR_STAT3, {6'h00, e[16:15]});
      rd_chk(ADDR_CORE, 8'h03);
      @(posedge clk_sys);
      async_flag <= 8'h00;
      wr(ADDR_FLAG_LO, 8'hFF);
      wr(ADDR_FLAG_HI, 8'hFF);
    end
    fire(5);
    fire(3);
    boundary(1'b0, 1'b0);
    chk({15'h0000, irq_req}, 16'h0000);
    @(posedge clk_sys);
    cli_exec <= 1'b1;
    @(posedge clk_sys);
    cli_exec <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({14'h0000, irq_req, global_mask}, 16'h0000);
    boundary(1'b0, 1'b0);
    entry(5'd3);
    wr(ADDR_FLAG_LO, 8'h04);
    boundary(1'b0, 1'b1);
    entry(5'd5);
    wr(ADDR_FLAG_LO, 8'h10);
    @(posedge clk_sys);
    resp_delay <= 4'h4;
    boundary(1'b1, 1'b0);
    entry(IDX_TRAP);
    // Mask instructions: clear, then set again, each seen on the mask output
    @(posedge clk_sys);
    cli_exec <= 1'b1;
    @(posedge clk_sys);
    cli_exec <= 1'b0;
    sei_exec <= 1'b1;
    #1;
    chk({15'h0000, global_mask}, 16'h0000);
    @(posedge clk_sys);
    sei_exec <= 1'b0;
    #1;
    chk({15'h0000, global_mask}, 16'h0001);
    @(posedge clk_sys);
    break_match <= 1'b1;
    @(posedge clk_sys);
    break_match <= 1'b0;
    #1;
    chk({15'h0000, force_trap_insn}, 16'h0001);
    finish_test();
  end
endmodule : prioritized_cpu_interrupt_logic_tb_top
`default_nettype wire
